// ---- rtl/pio_top.sv ----
`timescale 1ns/1ps
`include "pio_defs.svh"
module pio_top #(
    parameter int                    WIDTH        = 32,
    parameter pio_pkg::pio_dir_type  DIR_MODE     = pio_pkg::PIO_DIR_BIDIR,
    parameter logic [31:0]           RESET_VALUE  = `PIO_OUT_RESET,
    parameter bit                    SET_CLEAR_EN = 1'b1,
    parameter bit                    EDGE_EN      = 1'b1,
    parameter pio_pkg::pio_edge_type EDGE_KIND    = pio_pkg::PIO_EDGE_RISE,
    parameter bit                    BIT_CLEAR_EN = 1'b1,
    parameter bit                    IRQ_EN       = 1'b1,
    parameter pio_pkg::pio_irq_type  IRQ_KIND     = pio_pkg::PIO_IRQ_EDGE
) (
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    input  wire logic [`PIO_ADDR_W-1:0] bus_addr,
    input  wire logic                   bus_read,
    input  wire logic                   bus_write,
    input  wire logic [`PIO_BUS_DW-1:0] bus_writedata,
    output logic      [`PIO_BUS_DW-1:0] bus_readdata,
    output logic                        irq,
    input  wire logic [WIDTH-1:0]       port_in,
    output logic      [WIDTH-1:0]       port_out,
    output logic      [WIDTH-1:0]       port_oe
);

    // build-time feature set; output-only builds lose all input features
    localparam bit HAS_IN   = (DIR_MODE != pio_pkg::PIO_DIR_OUT);
    localparam bit HAS_OUT  = (DIR_MODE != pio_pkg::PIO_DIR_IN);
    localparam bit HAS_DIR  = (DIR_MODE == pio_pkg::PIO_DIR_BIDIR);
    localparam bit HAS_EDGE = EDGE_EN && HAS_IN;
    localparam bit HAS_IRQ  = IRQ_EN && HAS_IN;
    localparam bit HAS_SC   = SET_CLEAR_EN && HAS_OUT;
    localparam logic [WIDTH-1:0] OUT_RESET = RESET_VALUE[WIDTH-1:0];
    localparam logic [WIDTH-1:0] OE_FIXED  = HAS_OUT ? '1 : '0;

    // width must stay inside one 32-bit register
    if (WIDTH < 1 || WIDTH > `PIO_MAX_WIDTH) begin : g_bad_width
        $error("port width must be 1 to 32");
    end

    function automatic logic hit(input logic [`PIO_ADDR_W-1:0] a,
                                 input logic [`PIO_ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    // zero-extend a port-wide value into a bus word
    function automatic logic [`PIO_BUS_DW-1:0] widen(input logic [WIDTH-1:0] v);
        logic [`PIO_BUS_DW-1:0] r;
        r = '0;
        r[WIDTH-1:0] = v;
        widen = r;
    endfunction

    logic             wr_value;
    logic             wr_dir;
    logic             wr_mask;
    logic             wr_edge;
    logic             wr_set;
    logic             wr_clr;
    logic [WIDTH-1:0] wdata;
    logic [WIDTH-1:0] in_val;
    logic [WIDTH-1:0] value_q;
    logic [WIDTH-1:0] dir_q;
    logic [WIDTH-1:0] mask_q;
    logic [WIDTH-1:0] flags;
    logic [`PIO_BUS_DW-1:0] rd_mux;
    logic             irq_d;

    logic [`PIO_BUS_DW-1:0] readdata_q;
    logic                   irq_q;
    logic [WIDTH-1:0]       port_out_q;
    logic [WIDTH-1:0]       port_oe_q;

    assign wdata  = bus_writedata[WIDTH-1:0];
    // input-only, in/out and bidirectional builds sample the pins
    assign in_val = HAS_IN ? port_in : '0;

    // write decode: absent registers take no write
    always_comb begin
        wr_value = 1'b0;
        wr_dir   = 1'b0;
        wr_mask  = 1'b0;
        wr_edge  = 1'b0;
        wr_set   = 1'b0;
        wr_clr   = 1'b0;
        if (!bus_write) begin
            wr_value = 1'b0;
        end else if (hit(bus_addr, `PIO_OFF_VALUE)) begin
            wr_value = HAS_OUT;
        end else if (hit(bus_addr, `PIO_OFF_DIRECTION)) begin
            wr_dir = HAS_DIR;
        end else if (hit(bus_addr, `PIO_OFF_IRQ_MASK)) begin
            wr_mask = HAS_IRQ;
        end else if (hit(bus_addr, `PIO_OFF_EDGE_FLAGS)) begin
            wr_edge = HAS_EDGE;
        end else if (hit(bus_addr, `PIO_OFF_OUT_SET)) begin
            wr_set = HAS_SC;
        end else if (hit(bus_addr, `PIO_OFF_OUT_CLEAR)) begin
            wr_clr = HAS_SC;
        end
    end

    pio_out_reg #(
        .WIDTH       (WIDTH),
        .RESET_VALUE (OUT_RESET),
        .HAS_OUT     (HAS_OUT),
        .HAS_SC      (HAS_SC)
    ) u_out (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .wr_value (wr_value),
        .wr_set   (wr_set),
        .wr_clr   (wr_clr),
        .wdata    (wdata),
        .value_q  (value_q)
    );

    pio_edge_if #(.WIDTH(WIDTH)) edge_bus ();

    assign edge_bus.sample   = in_val;
    assign edge_bus.clr_wr   = wr_edge;
    assign edge_bus.clr_data = wdata;
    assign flags             = edge_bus.flags;

    pio_edge_cap #(
        .WIDTH        (WIDTH),
        .HAS_EDGE     (HAS_EDGE),
        .EDGE_KIND    (EDGE_KIND),
        .BIT_CLEAR_EN (BIT_CLEAR_EN)
    ) u_edge (
        .clk_sys (clk_sys),
        .rst     (rst),
        .e       (edge_bus)
    );

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dir_q <= WIDTH'(`PIO_DIR_RESET);
        end else if (wr_dir) begin
            dir_q <= wdata;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mask_q <= WIDTH'(`PIO_MASK_RESET);
        end else if (wr_mask) begin
            mask_q <= wdata;
        end
    end

    // read mux; absent and unmapped words read as zero
    always_comb begin
        rd_mux = '0;
        if (hit(bus_addr, `PIO_OFF_VALUE)) begin
            rd_mux = widen(in_val);
        end else if (hit(bus_addr, `PIO_OFF_DIRECTION)) begin
            rd_mux = HAS_DIR ? widen(dir_q) : '0;
        end else if (hit(bus_addr, `PIO_OFF_IRQ_MASK)) begin
            rd_mux = HAS_IRQ ? widen(mask_q) : '0;
        end else if (hit(bus_addr, `PIO_OFF_EDGE_FLAGS)) begin
            rd_mux = HAS_EDGE ? widen(flags) : '0;
        end
    end

    // one cycle read latency keeps the bus output on a flop
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            readdata_q <= '0;
        end else if (bus_read) begin
            readdata_q <= rd_mux;
        end
    end

    always_comb begin
        irq_d = 1'b0;
        if (!HAS_IRQ) begin
            irq_d = 1'b0;
        end else if (IRQ_KIND == pio_pkg::PIO_IRQ_LEVEL) begin
            irq_d = |(in_val & mask_q);
        end else begin
            irq_d = |(flags & mask_q);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    // pins: bidirectional bits drive only while set as outputs
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            port_out_q <= HAS_OUT ? OUT_RESET : '0;
            port_oe_q  <= '0;
        end else begin
            port_out_q <= value_q;
            port_oe_q  <= HAS_DIR ? dir_q : OE_FIXED;
        end
    end

    assign bus_readdata = readdata_q;
    assign irq          = irq_q;
    assign port_out     = port_out_q;
    assign port_oe      = port_oe_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    value_write_a: assert property (
        (wr_value && !wr_set && !wr_clr) |-> ##2 (port_out == $past(wdata, 2)))
        else $error("output value write not seen on port");

    dir_write_a: assert property (
        (HAS_DIR && bus_write && hit(bus_addr, `PIO_OFF_DIRECTION))
        |-> ##2 (port_oe == $past(wdata, 2)))
        else $error("direction write not seen on enables");

    read_value_a: assert property (
        (bus_read && hit(bus_addr, `PIO_OFF_VALUE))
        |=> (bus_readdata == widen($past(in_val))))
        else $error("data read does not return inputs");

    read_upper_a: assert property (
        (WIDTH < `PIO_BUS_DW) |-> ((bus_readdata >> WIDTH) == '0))
        else $error("bits above the port width read nonzero");

    irq_level_a: assert property (
        (HAS_IRQ && IRQ_KIND == pio_pkg::PIO_IRQ_LEVEL && (in_val & mask_q) != '0)
        |=> irq)
        else $error("level interrupt missing");

    irq_edge_a: assert property (
        (HAS_IRQ && IRQ_KIND == pio_pkg::PIO_IRQ_EDGE)
        |=> (irq == ($past(flags & mask_q) != '0)))
        else $error("edge interrupt does not follow masked flags");

    no_irq_a: assert property (
        !HAS_IRQ |-> (!irq && mask_q == '0))
        else $error("interrupt logic present without generation");

    // sampled at the first edge after release, so every flop still shows its reset value
    reset_state_a: assert property (
        $fell(rst) |-> (port_oe == '0 && dir_q == '0 && mask_q == '0
        && port_out == (HAS_OUT ? OUT_RESET : '0)))
        else $error("state after reset release is wrong");

    input_only_a: assert property (
        !HAS_OUT |-> (port_out == '0 && port_oe == '0))
        else $error("input-only build drives its port");

    out_only_edge_a: assert property (
        !HAS_IN |-> (flags == '0 && !irq))
        else $error("output-only build shows input features");

    set_then_irq_c: cover property (wr_mask ##[1:20] irq);
    bidir_drive_c: cover property (HAS_DIR && wr_dir ##2 (port_oe != '0));
    set_clear_c: cover property (wr_set ##[1:10] wr_clr);

endmodule

// ---- rtl/pio_defs.svh ----
`ifndef PIO_DEFS_SVH
`define PIO_DEFS_SVH

// register word offsets on the slave port
`define PIO_ADDR_W          3
`define PIO_BUS_DW          32
`define PIO_OFF_VALUE       3'h0
`define PIO_OFF_DIRECTION   3'h1
`define PIO_OFF_IRQ_MASK    3'h2
`define PIO_OFF_EDGE_FLAGS  3'h3
`define PIO_OFF_OUT_SET     3'h4
`define PIO_OFF_OUT_CLEAR   3'h5

// widest port and reset values
`define PIO_MAX_WIDTH       32
`define PIO_DIR_RESET       32'h0000_0000
`define PIO_MASK_RESET      32'h0000_0000
`define PIO_OUT_RESET       32'h0000_0000

`endif

// ---- rtl/pio_pkg.sv ----
package pio_pkg;

    typedef enum logic [1:0] {
        PIO_DIR_BIDIR,
        PIO_DIR_IN,
        PIO_DIR_OUT,
        PIO_DIR_INOUT
    } pio_dir_type;

    typedef enum logic [1:0] {
        PIO_EDGE_RISE,
        PIO_EDGE_FALL,
        PIO_EDGE_ANY
    } pio_edge_type;

    typedef enum logic {
        PIO_IRQ_LEVEL,
        PIO_IRQ_EDGE
    } pio_irq_type;

endpackage

// ---- rtl/pio_edge_if.sv ----
`timescale 1ns/1ps
interface pio_edge_if #(
    parameter int WIDTH = 32
);
    logic [WIDTH-1:0] sample;
    logic             clr_wr;
    logic [WIDTH-1:0] clr_data;
    logic [WIDTH-1:0] flags;

    modport ctrl (
        output sample,
        output clr_wr,
        output clr_data,
        input  flags
    );

    modport cap (
        input  sample,
        input  clr_wr,
        input  clr_data,
        output flags
    );
endinterface

// ---- rtl/pio_out_reg.sv ----
`timescale 1ns/1ps
module pio_out_reg #(
    parameter int               WIDTH       = 32,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0,
    parameter bit               HAS_OUT     = 1'b1,
    parameter bit               HAS_SC      = 1'b1
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             wr_value,
    input  wire logic             wr_set,
    input  wire logic             wr_clr,
    input  wire logic [WIDTH-1:0] wdata,
    output logic      [WIDTH-1:0] value_q
);

    logic [WIDTH-1:0] set_mask;
    logic [WIDTH-1:0] clr_mask;

    assign set_mask = (HAS_SC && wr_set) ? wdata : '0;
    assign clr_mask = (HAS_SC && wr_clr) ? wdata : '0;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            value_q <= HAS_OUT ? RESET_VALUE : '0;
        end else if (!HAS_OUT) begin
            value_q <= '0;
        end else if (wr_value) begin
            value_q <= wdata;
        end else begin
            // untouched bits keep their value
            value_q <= (value_q | set_mask) & ~clr_mask;
        end
    end

    set_bits_a: assert property (@(posedge clk_sys) disable iff (rst)
        (HAS_OUT && HAS_SC && wr_set) |=> ((value_q & $past(wdata)) == $past(wdata)))
        else $error("set write did not raise chosen bits");

    keep_bits_a: assert property (@(posedge clk_sys) disable iff (rst)
        (HAS_SC && wr_clr) |=> ((value_q & ~$past(wdata)) == ($past(value_q) & ~$past(wdata))))
        else $error("clear write disturbed other bits");

endmodule

// ---- rtl/pio_edge_cap.sv ----
`timescale 1ns/1ps
module pio_edge_cap #(
    parameter int                    WIDTH        = 32,
    parameter bit                    HAS_EDGE     = 1'b1,
    parameter pio_pkg::pio_edge_type EDGE_KIND    = pio_pkg::PIO_EDGE_RISE,
    parameter bit                    BIT_CLEAR_EN = 1'b1
) (
    input  wire logic clk_sys,
    input  wire logic rst,
    pio_edge_if.cap   e
);

    logic [WIDTH-1:0] prev_q;
    logic             primed_q;
    logic [WIDTH-1:0] flags_q;
    logic [WIDTH-1:0] det;
    logic [WIDTH-1:0] clr;

    // the first cycle after reset has no valid history, so no edge is seen
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prev_q   <= '0;
            primed_q <= 1'b0;
        end else begin
            prev_q   <= e.sample;
            primed_q <= 1'b1;
        end
    end

    always_comb begin
        det = '0;
        if (primed_q) begin
            case (EDGE_KIND)
                pio_pkg::PIO_EDGE_RISE: det = e.sample & ~prev_q;
                pio_pkg::PIO_EDGE_FALL: det = ~e.sample & prev_q;
                default:                det = e.sample ^ prev_q;
            endcase
        end
    end

    always_comb begin
        clr = '0;
        if (e.clr_wr) begin
            clr = BIT_CLEAR_EN ? e.clr_data : '1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            flags_q <= '0;
        end else if (!HAS_EDGE) begin
            flags_q <= '0;
        end else begin
            // a new edge beats a clear in the same cycle
            flags_q <= (flags_q & ~clr) | det;
        end
    end

    assign e.flags = flags_q;

    edge_flag_set_a: assert property (@(posedge clk_sys) disable iff (rst)
        (HAS_EDGE && primed_q && det[0]) |=> flags_q[0])
        else $error("edge did not set its flag next cycle");

    rise_only_a: assert property (@(posedge clk_sys) disable iff (rst)
        (HAS_EDGE && EDGE_KIND == pio_pkg::PIO_EDGE_RISE && !flags_q[0]
         && !(e.sample[0] && !prev_q[0])) |=> !flags_q[0])
        else $error("flag set without a rising edge");

    flag_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
        (BIT_CLEAR_EN && e.clr_wr && e.clr_data[0] && !det[0]) |=> !flags_q[0])
        else $error("flag not cleared by a one");

    flag_keep_a: assert property (@(posedge clk_sys) disable iff (rst)
        (BIT_CLEAR_EN && e.clr_wr && !e.clr_data[0] && flags_q[0]) |=> flags_q[0])
        else $error("flag lost on a zero write");

    clear_all_a: assert property (@(posedge clk_sys) disable iff (rst)
        (HAS_EDGE && !BIT_CLEAR_EN && e.clr_wr && det == '0) |=> (flags_q == '0))
        else $error("write did not clear all flags");

    edge_seen_c: cover property (@(posedge clk_sys) disable iff (rst)
        HAS_EDGE && det[0] ##1 e.clr_wr);

endmodule

// ---- tb/pio_host_model.sv ----
`timescale 1ns/1ps
// host side of the register port; each access is followed by an idle cycle
module pio_host_model (
    input  wire logic        clk_sys,
    output logic      [2:0]  bus_addr,
    output logic             bus_read,
    output logic             bus_write,
    output logic      [31:0] bus_writedata,
    input  wire logic [31:0] bus_readdata
);
    initial begin
        bus_addr      = 3'h7;
        bus_read      = 1'b0;
        bus_write     = 1'b0;
        bus_writedata = 32'h0;
    end

    task automatic access(input logic wr, input logic [31:0] byte_addr,
                          input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_sys);
        #2;
        bus_addr      = byte_addr[4:2];
        bus_writedata = wd;
        bus_write     = wr;
        bus_read      = !wr;
        @(posedge clk_sys);
        #2;
        bus_write     = 1'b0;
        bus_read      = 1'b0;
        // released lines must not keep showing the old value
        bus_addr      = ~bus_addr;
        bus_writedata = ~bus_writedata;
        @(posedge clk_sys);
        #2;
        rd = bus_readdata;
    endtask
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    localparam int          W  = 12;
    localparam logic [31:0] RV = 32'h0000_05A3;
    localparam logic [31:0] WM = 32'h0000_0FFF;

    logic         clk_sys;
    logic         rst;
    logic [2:0]   bus_addr;
    logic         bus_read;
    logic         bus_write;
    logic [31:0]  bus_writedata;
    logic [31:0]  bus_readdata;
    logic         irq;
    logic [W-1:0] ext_val;
    logic [W-1:0] port_in;
    logic [W-1:0] port_out;
    logic [W-1:0] port_oe;
    int           fail_count;
    int           checked;

    // pin level: the block where it drives, the outside world elsewhere
    assign port_in = (port_out & port_oe) | (ext_val & ~port_oe);

    pio_top #(
        .WIDTH        (W),
        .DIR_MODE     (pio_pkg::PIO_DIR_BIDIR),
        .RESET_VALUE  (RV),
        .SET_CLEAR_EN (1'b1),
        .EDGE_EN      (1'b1),
        .EDGE_KIND    (pio_pkg::PIO_EDGE_RISE),
        .BIT_CLEAR_EN (1'b1),
        .IRQ_EN       (1'b1),
        .IRQ_KIND     (pio_pkg::PIO_IRQ_EDGE)
    ) u_pio_top (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .bus_addr      (bus_addr),
        .bus_read      (bus_read),
        .bus_write     (bus_write),
        .bus_writedata (bus_writedata),
        .bus_readdata  (bus_readdata),
        .irq           (irq),
        .port_in       (port_in),
        .port_out      (port_out),
        .port_oe       (port_oe)
    );

    pio_host_model u_pio_host_model (
        .clk_sys       (clk_sys),
        .bus_addr      (bus_addr),
        .bus_read      (bus_read),
        .bus_write     (bus_write),
        .bus_writedata (bus_writedata),
        .bus_readdata  (bus_readdata)
    );

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] exp_pins(input logic [31:0] o, input logic [31:0] oe,
                                             input logic [31:0] e);
        return ((o & oe) | (e & ~oe)) & WM;
    endfunction

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp, input string what);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [2:0] off, input logic [31:0] d);
        logic [31:0] unused;
        u_pio_host_model.access(1'b1, {27'h0, off, 2'b00}, d, unused);
    endtask

    task automatic rd(input logic [2:0] off, output logic [31:0] r);
        u_pio_host_model.access(1'b0, {27'h0, off, 2'b00}, 32'h0, r);
    endtask

    task automatic complete_run;
        $display("checks %0d errors %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        $display("Error at %0t: run did not finish", $time);
        complete_run();
    end

    initial begin
        logic [31:0] r;
        logic [31:0] d;
        logic [31:0] v;
        logic [31:0] s;
        logic [31:0] o;
        logic [2:0]  zero_offs [4];
        zero_offs = '{3'h1, 3'h2, 3'h6, 3'h7};
        rst = 1'b1;
        ext_val = '0;
        fail_count = 0;
        checked = 0;
        void'($urandom(32'h3A60));
        repeat (12) @(posedge clk_sys);
        #2;
        rst = 1'b0;
        check_word({20'h0, port_out}, RV & WM, "reset output");
        check_word({20'h0, port_oe}, 32'h0, "reset enable");
        foreach (zero_offs[i]) begin
            rd(zero_offs[i], r);
            check_word(r, 32'h0, "reset or unmapped read");
        end
        repeat (6) begin
            d = $urandom();
            wr(3'h0, d);
            o = d & WM;
            v = $urandom();
            wr(3'h1, v);
            ext_val = W'($urandom());
            s = $urandom();
            wr(3'h4, s);
            o = o | (s & WM);
            s = $urandom();
            wr(3'h5, s);
            o = o & ~s;
            // a write to an unmapped offset must not alias onto a real one
            wr(3'h6, $urandom());
            check_word({20'h0, port_out}, o, "output value");
            check_word({20'h0, port_oe}, v & WM, "pin enable");
            rd(3'h0, r);
            check_word(r, exp_pins(o, v, {20'h0, ext_val}), "pin read");
            rd(3'h1, r);
            check_word(r, v & WM, "direction read");
        end
        wr(3'h1, 32'h0);
        ext_val = '0;
        wr(3'h2, 32'h0);
        wr(3'h3, 32'hFFFF_FFFF);
        rd(3'h3, r);
        check_word(r, 32'h0, "flags cleared");
        d = ($urandom() & WM) | 32'h801;
        ext_val = d[W-1:0];
        repeat (3) @(posedge clk_sys);
        #2;
        check_bit(irq, 1'b0, "masked irq");
        rd(3'h3, r);
        check_word(r, d, "rising flags");
        ext_val = '0;
        repeat (3) @(posedge clk_sys);
        rd(3'h3, r);
        check_word(r, d, "falling ignored");
        wr(3'h2, 32'h1);
        check_bit(irq, 1'b1, "edge irq");
        rd(3'h2, r);
        check_word(r, 32'h1, "mask read");
        wr(3'h3, 32'h1);
        check_bit(irq, 1'b0, "irq after clear");
        rd(3'h3, r);
        check_word(r, d & ~32'h1, "single flag clear");
        wr(3'h2, 32'h800);
        check_bit(irq, 1'b1, "top bit irq");
        complete_run();
    end
endmodule
